// file: design/drsl_top.sv
// DS3 receive status latching, count flags and interrupt request for one port.
// Assumes framer flags, error pulses and counts arrive on clk, and an APB master.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

// Operation
// - C-bit parity count flag is one when count nonzero, zero in M23.
// - Far-end block count flag is one when count nonzero, zero in M23.
// - P-bit parity count flag is one when that count is nonzero.
// - Framing count flag is one when count nonzero; event kind follows selection.
// - Format mismatch latch sets only on rising edge of the live flag.
// - Each other live flag latch sets on any change of state.
// - Alignment latch sets when a new alignment differs from the previous one.
// - C-bit and far-end error latches set per error, held zero in M23.
// - P-bit parity error latch sets on each detected P-bit error.
// - Framing error latch sets on each framing event chosen by the selection.
// - Count latches set on zero-to-one of count flags; C-bit, far-end zero in M23.
// - Request needs latch set, its enable one and port global enable set.
// - Selection 00 out-of-frame, 01 M or F, 10 F only, 11 M only.
// - Second enable register gates error and count latches with global enable.
module drsl_top import drsl_pkg::*; (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              format_mismatch,
  input  wire logic              app_id_channel,
  input  wire logic              idle_signal,
  input  wire logic              unframed_all_ones,
  input  wire logic              multiframe_loss,
  input  wire logic              severely_errored_frame,
  input  wire logic              frame_loss,
  input  wire logic              remote_defect,
  input  wire logic              alarm_signal,
  input  wire logic              out_of_frame,
  input  wire logic              signal_loss,
  input  wire logic              align_load,
  input  wire logic [ALIGN_W-1:0] align_pos,
  input  wire logic              cbit_parity_err,
  input  wire logic              far_end_block_err,
  input  wire logic              pbit_parity_err,
  input  wire logic              m_bit_err,
  input  wire logic              f_bit_err,
  input  wire logic [CNT_W-1:0]  cbit_parity_count,
  input  wire logic [CNT_W-1:0]  far_end_block_count,
  input  wire logic [CNT_W-1:0]  pbit_parity_count,
  input  wire logic [CNT_W-1:0]  framing_count
);

  logic [REG_W-1:0]   ctrl_q;
  logic [REG_W-1:0]   ie1_q;
  logic [REG_W-1:0]   ie2_q;
  logic [REG_W-1:0]   lat1_q;
  logic [REG_W-1:0]   lat1_d;
  logic [REG_W-1:0]   lat2_q;
  logic [REG_W-1:0]   lat2_d;
  logic [REG_W-1:0]   set1;
  logic [REG_W-1:0]   set2;
  logic [REG_W-1:0]   clr1;
  logic [REG_W-1:0]   clr2;
  logic [NCNT-1:0]    cnt_q;
  logic [NCNT-1:0]    cnt_d;
  logic [NCNT-1:0]    cnt_rise;
  logic [LIVE_W-1:0]  live_v;
  logic [LIVE_W-1:0]  live_rise;
  logic [LIVE_W-1:0]  live_chg;
  logic [ALIGN_W-1:0] align_prev_q;
  logic               align_seen_q;
  logic               align_change;
  logic               armed_q;
  logic               m23;
  logic               port_irq_en;
  drsl_fcs_t          fcs;
  logic               frame_event;
  logic [REG_W-1:0]   rd_val;
  logic               rd_hit;
  logic               setup;
  logic               access;
  logic               wr_ctrl;
  logic               wr_ie1;
  logic               wr_ie2;
  logic               wr_lat1;
  logic               wr_lat2;
  logic [DATA_W-1:0]  prdata_q;
  logic               pslverr_q;
  logic               irq_q;

  assign m23         = ctrl_q[CTRL_M23_BIT];
  assign port_irq_en = ctrl_q[CTRL_PIE_BIT];
  assign fcs         = drsl_fcs_t'(ctrl_q[CTRL_FCS_LSB+1:CTRL_FCS_LSB]);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  // Live flags in latched-register bit order; the alignment slot has no level.
  assign live_v = {format_mismatch, app_id_channel, idle_signal, unframed_all_ones,
                   multiframe_loss, severely_errored_frame, 1'b0, frame_loss,
                   remote_defect, alarm_signal, out_of_frame, signal_loss};

  drsl_chg_det #(.W(LIVE_W)) u_live_det (
    .clk     (clk),
    .reset_n (reset_n),
    .arm     (armed_q),
    .cur     (live_v),
    .rise    (live_rise),
    .change  (live_chg)
  );

  assign cnt_d[C_CBIT]  = (cbit_parity_count != '0) & ~m23;
  assign cnt_d[C_FEBE]  = (far_end_block_count != '0) & ~m23;
  assign cnt_d[C_PBIT]  = (pbit_parity_count != '0);
  assign cnt_d[C_FRAME] = (framing_count != '0);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  drsl_chg_det #(.W(NCNT)) u_cnt_det (
    .clk     (clk),
    .reset_n (reset_n),
    .arm     (armed_q),
    .cur     (cnt_q),
    .rise    (cnt_rise),
    .change  ()
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      align_prev_q <= '0;
      align_seen_q <= 1'b0;
    end else if (align_load) begin
      align_prev_q <= align_pos;
      align_seen_q <= 1'b1;
    end
  end

  assign align_change = align_load & align_seen_q & (align_pos != align_prev_q);

  always_comb begin
    case (fcs)
      FCS_OOF: frame_event = live_rise[B_OUT_OF_FRAME];
      FCS_MF:  frame_event = m_bit_err | f_bit_err;
      FCS_F:   frame_event = f_bit_err;
      FCS_M:   frame_event = m_bit_err;
      default: frame_event = 1'b0;
    endcase
  end

  always_comb begin
    set1                    = {{(REG_W-LIVE_W){1'b0}}, live_chg & LIVE_CHG};
    set1[B_FORMAT_MISMATCH] = live_rise[B_FORMAT_MISMATCH];
    set1[B_ALIGN_CHANGE]    = align_change;
  end

  always_comb begin
    set2               = '0;
    set2[B_CBIT_ERR]   = cbit_parity_err & ~m23;
    set2[B_FEBE_ERR]   = far_end_block_err & ~m23;
    set2[B_PBIT_ERR]   = pbit_parity_err;
    set2[B_FRAME_ERR]  = frame_event;
    set2[B_CBIT_RISE]  = cnt_rise[C_CBIT] & ~m23;
    set2[B_FEBE_RISE]  = cnt_rise[C_FEBE] & ~m23;
    set2[B_PBIT_RISE]  = cnt_rise[C_PBIT];
    set2[B_FRAME_RISE] = cnt_rise[C_FRAME];
  end

  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr_ctrl = access & pwrite & (paddr == ADDR_CTRL);
  assign wr_ie1  = access & pwrite & (paddr == ADDR_IE1);
  assign wr_ie2  = access & pwrite & (paddr == ADDR_IE2);
  assign wr_lat1 = access & pwrite & (paddr == ADDR_LAT1);
  assign wr_lat2 = access & pwrite & (paddr == ADDR_LAT2);

  assign clr1 = wr_lat1 ? (pwdata[REG_W-1:0] & LAT1_MASK) : '0;
  assign clr2 = wr_lat2 ? (pwdata[REG_W-1:0] & LAT2_MASK) : '0;

  // A new event in the clearing cycle wins; M23 mode still forces its bits low.
  assign lat1_d = ((lat1_q & ~clr1) | set1) & LAT1_MASK;
  assign lat2_d = ((lat2_q & ~clr2) | set2) & LAT2_MASK & ~(m23 ? LAT2_M23 : '0);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lat1_q <= RST_REG;
      lat2_q <= RST_REG;
    end else begin
      lat1_q <= lat1_d;
      lat2_q <= lat2_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= RST_REG;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[REG_W-1:0] & CTRL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ie1_q <= RST_REG;
    end else if (wr_ie1) begin
      ie1_q <= pwdata[REG_W-1:0] & LAT1_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ie2_q <= RST_REG;
    end else if (wr_ie2) begin
      ie2_q <= pwdata[REG_W-1:0] & LAT2_MASK;
    end
  end

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (paddr == ADDR_CTRL) begin
      rd_val = ctrl_q;
    end else if (paddr == ADDR_LIVE) begin
      rd_val = {{(REG_W-LIVE_W){1'b0}}, live_v};
    end else if (paddr == ADDR_CNT) begin
      rd_val = {{(REG_W-NCNT){1'b0}}, cnt_q};
    end else if (paddr == ADDR_LAT1) begin
      rd_val = lat1_q;
    end else if (paddr == ADDR_LAT2) begin
      rd_val = lat2_q;
    end else if (paddr == ADDR_IE1) begin
      rd_val = ie1_q;
    end else if (paddr == ADDR_IE2) begin
      rd_val = ie2_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data and error are captured in the setup cycle and stand through access.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= {{(DATA_W-REG_W){1'b0}}, rd_val};
      pslverr_q <= ~rd_hit;
    end else if (!psel) begin
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= port_irq_en & ((|(lat1_q & ie1_q)) | (|(lat2_q & ie2_q)));
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign pready  = access;
  assign irq     = irq_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_m23_held;
    m23 ##1 m23;
  endsequence
  sequence s_live_moved;
    armed_q && ((live_v ^ $past(live_v)) & LIVE_CHG) != '0;
  endsequence

  property p_cbit_flag_m23;
    m23 |=> !cnt_q[C_CBIT] && !cnt_q[C_FEBE];
  endproperty
  a_cbit_flag_m23: assert property (p_cbit_flag_m23)
    else $error("Count flag set in M23 mode.");
  property p_pbit_flag;
    (pbit_parity_count != '0) [*2] |-> cnt_q[C_PBIT];
  endproperty
  a_pbit_flag: assert property (p_pbit_flag)
    else $error("P-bit count flag low with nonzero count.");
  property p_fm_rise;
    armed_q && $rose(format_mismatch) |=> lat1_q[B_FORMAT_MISMATCH];
  endproperty
  a_fm_rise: assert property (p_fm_rise)
    else $error("Format mismatch rise not latched.");
  property p_fm_fall;
    $fell(format_mismatch) && !lat1_q[B_FORMAT_MISMATCH] |=> !lat1_q[B_FORMAT_MISMATCH];
  endproperty
  a_fm_fall: assert property (p_fm_fall)
    else $error("Format mismatch fall was latched.");
  property p_live_change;
    s_live_moved |=> ((($past(live_v) ^ $past(live_v, 2)) & LIVE_CHG) & ~lat1_q[LIVE_W-1:0]) == '0;
  endproperty
  a_live_change: assert property (p_live_change)
    else $error("Live flag change not latched.");
  property p_align;
    align_load && align_seen_q && (align_pos != align_prev_q) |=> lat1_q[B_ALIGN_CHANGE];
  endproperty
  a_align: assert property (p_align)
    else $error("Alignment change not latched.");
  property p_m23_hold;
    s_m23_held |-> (lat2_q & LAT2_M23) == '0;
  endproperty
  a_m23_hold: assert property (p_m23_hold)
    else $error("C-bit or far-end latch set in M23 mode.");
  property p_pbit_err;
    pbit_parity_err |=> lat2_q[B_PBIT_ERR];
  endproperty
  a_pbit_err: assert property (p_pbit_err)
    else $error("P-bit error not latched.");
  property p_frame_sel;
    (fcs == FCS_F && f_bit_err) || (fcs == FCS_M && m_bit_err) |=> lat2_q[B_FRAME_ERR];
  endproperty
  a_frame_sel: assert property (p_frame_sel)
    else $error("Selected framing event not latched.");
  property p_frame_oof;
    armed_q && fcs == FCS_OOF && $rose(out_of_frame) |=> lat2_q[B_FRAME_ERR];
  endproperty
  a_frame_oof: assert property (p_frame_oof)
    else $error("Out-of-frame occurrence not latched.");
  property p_count_rise;
    armed_q && $rose(cnt_q[C_PBIT]) |=> lat2_q[B_PBIT_RISE];
  endproperty
  a_count_rise: assert property (p_count_rise)
    else $error("Count flag rise not latched.");
  property p_irq_blocked;
    !port_irq_en |=> !irq;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked)
    else $error("Interrupt without port enable.");
  property p_irq_raise;
    port_irq_en && ((lat1_q & ie1_q) != '0 || (lat2_q & ie2_q) != '0) |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("Enabled latch raised no interrupt.");
  property p_irq_fall;
    (lat1_q & ie1_q) == '0 && (lat2_q & ie2_q) == '0 |=> !irq;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("Interrupt stayed with no enabled latch.");
  property p_lat_hold;
    lat2_q[B_PBIT_ERR] && !(wr_lat2 && pwdata[B_PBIT_ERR]) |=> lat2_q[B_PBIT_ERR];
  endproperty
  a_lat_hold: assert property (p_lat_hold)
    else $error("Latched bit lost without write of one.");

endmodule : drsl_top

// file: design/drsl_pkg.sv
// Constants and types for the DS3 receive status latch and interrupt block.
// Assumes an APB slave with 32-bit data where each register takes one aligned word.
package drsl_pkg;

  localparam int DATA_W  = 32;
  localparam int REG_W   = 16;
  localparam int ADDR_W  = 8;
  localparam int LIVE_W  = 12;
  localparam int CNT_W   = 16;
  localparam int ALIGN_W = 13;
  localparam int NCNT    = 4;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_LIVE = 8'h24;
  localparam logic [7:0] IDX_CNT  = 8'h26;
  localparam logic [7:0] IDX_LAT1 = 8'h28;
  localparam logic [7:0] IDX_LAT2 = 8'h2A;
  localparam logic [7:0] IDX_IE1  = 8'h2C;
  localparam logic [7:0] IDX_IE2  = 8'h2E;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LIVE = {IDX_LIVE[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CNT  = {IDX_CNT[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LAT1 = {IDX_LAT1[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LAT2 = {IDX_LAT2[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IE1  = {IDX_IE1[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IE2  = {IDX_IE2[5:0], 2'b00};

  // Bit positions in the first latched register and the live status word.
  localparam int B_FORMAT_MISMATCH = 11;
  localparam int B_ALIGN_CHANGE    = 5;
  localparam int B_OUT_OF_FRAME    = 1;

  // Bit positions in the second latched register.
  localparam int B_CBIT_ERR   = 11;
  localparam int B_FEBE_ERR   = 10;
  localparam int B_PBIT_ERR   = 9;
  localparam int B_FRAME_ERR  = 8;
  localparam int B_CBIT_RISE  = 3;
  localparam int B_FEBE_RISE  = 2;
  localparam int B_PBIT_RISE  = 1;
  localparam int B_FRAME_RISE = 0;

  // Bit positions in the count flag register.
  localparam int C_CBIT  = 3;
  localparam int C_FEBE  = 2;
  localparam int C_PBIT  = 1;
  localparam int C_FRAME = 0;

  // Control register fields.
  localparam int CTRL_FCS_LSB = 8;
  localparam int CTRL_M23_BIT = 4;
  localparam int CTRL_PIE_BIT = 0;

  localparam logic [REG_W-1:0]  LAT1_MASK   = 16'h0FFF;
  localparam logic [REG_W-1:0]  LAT2_MASK   = 16'h0F0F;
  localparam logic [REG_W-1:0]  LAT2_M23    = 16'h0C0C;
  localparam logic [REG_W-1:0]  CTRL_MASK   = 16'h0311;
  localparam logic [LIVE_W-1:0] LIVE_CHG    = 12'h7DF;
  localparam logic [REG_W-1:0]  RST_REG     = 16'h0000;

  typedef enum logic [1:0] {
    FCS_OOF  = 2'b00,
    FCS_MF   = 2'b01,
    FCS_F    = 2'b10,
    FCS_M    = 2'b11
  } drsl_fcs_t;

endpackage : drsl_pkg

// file: design/drsl_chg_det.sv
// Per-bit rise and change detector for a vector of level flags.
// Assumes the flags come from logic on the same clock; arm stays low until prev is valid.
`timescale 1ns/1ps
module drsl_chg_det import drsl_pkg::*; #(
  parameter int W = LIVE_W
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         arm,
  input  wire logic [W-1:0] cur,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] change
);

  logic [W-1:0] prev_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= cur;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign rise[i]   = arm & cur[i] & ~prev_q[i];
      assign change[i] = arm & (cur[i] ^ prev_q[i]);
    end
  endgenerate

endmodule : drsl_chg_det

// file: tb/tb.sv
// Self-checking testbench for the receive status latch and interrupt block.
// Assumes drsl_pkg and drsl_top are compiled first; APB master and framer are driven here.
`timescale 1ns/1ps
module tb;
  import drsl_pkg::*;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic [11:0]       live = '0;
  logic              align_load = 1'b0;
  logic [ALIGN_W-1:0] align_pos = '0;
  logic [4:0]        errs = '0;
  logic [CNT_W-1:0]  cnt_c = '0;
  logic [CNT_W-1:0]  cnt_b = '0;
  logic [CNT_W-1:0]  cnt_p = '0;
  logic [CNT_W-1:0]  cnt_f = '0;
  int                mismatches = 0;
  int                num_checks = 0;

  always #12.5 clk = ~clk;

  drsl_top dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .format_mismatch(live[11]), .app_id_channel(live[10]),
    .idle_signal(live[9]), .unframed_all_ones(live[8]), .multiframe_loss(live[7]),
    .severely_errored_frame(live[6]), .frame_loss(live[4]), .remote_defect(live[3]),
    .alarm_signal(live[2]), .out_of_frame(live[1]), .signal_loss(live[0]),
    .align_load(align_load), .align_pos(align_pos), .cbit_parity_err(errs[4]),
    .far_end_block_err(errs[3]), .pbit_parity_err(errs[2]), .m_bit_err(errs[1]),
    .f_bit_err(errs[0]), .cbit_parity_count(cnt_c), .far_end_block_count(cnt_b),
    .pbit_parity_count(cnt_p), .framing_count(cnt_f)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // One APB transfer; the answer is taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    check(rd, exp);
  endtask : rd_chk

  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    errs <= v;
    @(posedge clk);
    errs <= '0;
    idle(2);
  endtask : pulse

  task automatic load_align(input logic [ALIGN_W-1:0] p);
    @(posedge clk);
    align_load <= 1'b1;
    align_pos  <= p;
    @(posedge clk);
    align_load <= 1'b0;
    idle(2);
  endtask : load_align

  task automatic t_reset;
    logic [31:0] rd;
    logic        e;
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_LAT1, 32'h0);
    rd_chk(ADDR_LAT2, 32'h0);
    rd_chk(ADDR_IE1, 32'h0);
    rd_chk(ADDR_IE2, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, 8'hFC, 32'h0, rd, e);
    check({31'h0, e}, 32'h1);
    check(rd, 32'h0);
    wr(ADDR_LIVE, 32'hFFFF);
    rd_chk(ADDR_LIVE, 32'h0);
    wr(ADDR_IE2, 32'hFFFF);
    rd_chk(ADDR_IE2, {16'h0, LAT2_MASK});
    wr(ADDR_IE2, 32'h0);
  endtask : t_reset

  task automatic t_live;
    logic [31:0] bitv;
    wr(ADDR_IE1, 32'h0FFF);
    wr(ADDR_CTRL, 32'h1);
    for (int i = 0; i < 12; i++) begin
      if (i != 5) begin
        bitv = 32'h1 << i;
        @(posedge clk);
        live[i] <= 1'b1;
        idle(3);
        rd_chk(ADDR_LAT1, bitv);
        check({31'h0, irq}, 32'h1);
        rd_chk(ADDR_LAT1, bitv);
        wr(ADDR_LAT1, bitv);
        idle(2);
        check({31'h0, irq}, 32'h0);
        @(posedge clk);
        live[i] <= 1'b0;
        idle(3);
        rd_chk(ADDR_LAT1, (i == 11) ? 32'h0 : bitv);
        wr(ADDR_LAT1, bitv);
      end
    end
    rd_chk(ADDR_LAT2, 32'h100);
    wr(ADDR_LAT2, 32'h100);
  endtask : t_live

  task automatic t_align;
    load_align(13'h0123);
    rd_chk(ADDR_LAT1, 32'h0);
    load_align(13'h0123);
    rd_chk(ADDR_LAT1, 32'h0);
    load_align(13'h0456);
    rd_chk(ADDR_LAT1, 32'h20);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_LAT1, 32'h20);
  endtask : t_align

  task automatic t_errs;
    logic [1:0] f;
    pulse(5'b00100);
    rd_chk(ADDR_LAT2, 32'h200);
    pulse(5'b11000);
    rd_chk(ADDR_LAT2, 32'hE00);
    wr(ADDR_LAT2, 32'hFFF);
    for (int k = 0; k < 4; k++) begin
      f = k[1:0];
      wr(ADDR_CTRL, {22'h0, f, 8'h00});
      pulse(5'b00010);
      rd_chk(ADDR_LAT2, f[0] ? 32'h100 : 32'h0);
      wr(ADDR_LAT2, 32'h100);
      pulse(5'b00001);
      rd_chk(ADDR_LAT2, (f[0] ^ f[1]) ? 32'h100 : 32'h0);
      wr(ADDR_LAT2, 32'h100);
      if (f == 2'b00) begin
        @(posedge clk);
        live[1] <= 1'b1;
        idle(3);
        rd_chk(ADDR_LAT2, 32'h100);
        @(posedge clk);
        live[1] <= 1'b0;
        wr(ADDR_LAT2, 32'h100);
        wr(ADDR_LAT1, 32'h2);
      end
    end
  endtask : t_errs

  task automatic t_m23;
    wr(ADDR_CTRL, 32'h11);
    pulse(5'b11000);
    rd_chk(ADDR_LAT2, 32'h0);
    @(posedge clk);
    cnt_c <= 16'h0005;
    cnt_b <= 16'h0005;
    cnt_p <= 16'h0005;
    cnt_f <= 16'h0005;
    idle(3);
    rd_chk(ADDR_CNT, 32'h3);
    rd_chk(ADDR_LAT2, 32'h3);
    wr(ADDR_LAT2, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    idle(3);
    rd_chk(ADDR_CNT, 32'hF);
    rd_chk(ADDR_LAT2, 32'hC);
    wr(ADDR_LAT2, 32'hF);
    @(posedge clk);
    cnt_c <= '0;
    cnt_b <= '0;
    cnt_p <= '0;
    cnt_f <= '0;
    idle(3);
    rd_chk(ADDR_CNT, 32'h0);
    @(posedge clk);
    cnt_p <= 16'h0001;
    idle(3);
    rd_chk(ADDR_LAT2, 32'h2);
    wr(ADDR_LAT2, 32'h2);
  endtask : t_m23

  task automatic t_gate;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_IE2, 32'h0);
    wr(ADDR_LAT1, 32'hFFF);
    wr(ADDR_LAT2, 32'hFFF);
    pulse(5'b00100);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_IE2, 32'h200);
    idle(2);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    idle(2);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_IE2, 32'h0);
    idle(2);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_IE2, 32'h200);
    @(posedge clk);
    live[0] <= 1'b1;
    idle(3);
    wr(ADDR_LAT2, 32'h200);
    idle(2);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_LAT1, 32'h1);
    idle(2);
    check({31'h0, irq}, 32'h0);
  endtask : t_gate

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    idle(3);
    t_reset();
    t_live();
    t_align();
    t_errs();
    t_m23();
    t_gate();
    end_sim();
  end

  initial begin
    #(25 * 20000);
    mismatches++;
    end_sim();
  end
endmodule : tb
